// [include/scp_pkg.sv]
// Shared constants for the serial configuration port and its host controller
package scp_pkg;
	// Instruction word layout
	localparam int INSTR_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int INSTR_RW = 15;
	localparam int INSTR_LEN_HI = 14;
	localparam int INSTR_LEN_LO = 13;
	localparam int ADDR_W = 10;
	localparam logic [1:0] LEN_STREAM = 2'h3;
	// Device register map
	localparam logic [9:0] ADDR_CFG = 10'h000;
	localparam logic [9:0] ADDR_RBSEL = 10'h004;
	localparam logic [9:0] ADDR_UPDATE = 10'h232;
	localparam logic [9:0] ADDR_LAST = 10'h232;
	localparam int REG_COUNT = 32'h00000233;
	localparam logic [7:0] CFG_RESET = 8'h18;
	localparam int CFG_SEP_LO = 0;
	localparam int CFG_LSB_LO = 1;
	localparam int CFG_LONG_LO = 3;
	localparam int CFG_LONG_HI = 4;
	localparam int UPDATE_BIT = 0;
	localparam int RBSEL_BIT = 0;
	// Serial clock made by the host
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCLK_PERIOD_NS = 125;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	// Host APB register map
	localparam logic [7:0] HREG_CTRL = 8'h00;
	localparam logic [7:0] HREG_TX = 8'h04;
	localparam logic [7:0] HREG_RX = 8'h08;
	localparam logic [7:0] HREG_STAT = 8'h0C;
	localparam int CTRL_LSB = 16;
	localparam int CTRL_SEP = 17;
	localparam int CTRL_START = 31;
	localparam int TX_LAST = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_TXFULL = 1;
	localparam int STAT_RXVALID = 2;
endpackage

// [include/scp_if.sv]
// Serial link between host controller and configuration port
`timescale 1ns/1ps
`default_nettype none
interface scp_if;
	logic sclk;
	logic cs_n;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic dev_sdo_o;
	logic dev_sdo_oe;
	// Resolved wire levels; an undriven line reads low
	logic sdio_lvl;
	logic sdo_lvl;
	assign sdio_lvl = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b0);
	assign sdo_lvl = dev_sdo_oe ? dev_sdo_o : 1'b0;
	modport device (
		input sclk, cs_n, sdio_lvl,
		output dev_sdio_o, dev_sdio_oe, dev_sdo_o, dev_sdo_oe
	);
	modport host (
		output sclk, cs_n, host_sdio_o, host_sdio_oe,
		input sdio_lvl, sdo_lvl
	);
endinterface
`default_nettype wire

// [src/scp_device.sv]
// Serial configuration port slave with shadow and active register banks
//
// Contract
// RQ1: 16-bit instruction: R/W, length, address
// RQ2: Length code 00/01/10 bytes, 11 streams
// RQ3: Write data sampled on serial rising edge
// RQ4: Chip select high on byte boundary stalls (code stalls sized transfers only; a stream returns to the instruction phase)
// RQ5: Chip select high mid-byte abandons transfer
// RQ6: Streaming writes touch every address
// RQ7: Host writes reserved defaults when streaming
// RQ8: Writes buffered; update bit copies, self-clears
// RQ9: Buffered bytes stay pending until update
// RQ10: Reads shift 8 bits per byte
// RQ11: Read data changes on falling edge
// RQ12: Readback on data pin or separate pin
// RQ13: Readback source chosen by select bit
// RQ14: Host keeps long-instruction bits set
// RQ15: Host keeps upper address bits zero
// RQ16: Configuration byte written nibble-mirrored
// RQ17: MSB first default; order change immediate
// RQ18: MSB first: decrementing address
// RQ19: LSB first: incrementing address
// RQ20: Streaming stops after address 0x232
// RQ21: Chip select high releases both outputs
// RQ22: Instruction from first 16 rising edges
// RQ23: Data pin driven only in read data
`timescale 1ns/1ps
`default_nettype none
module scp_device (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Serial link
	scp_if.device LINK,
	// Active register lookup for the rest of the chip
	input wire logic [9:0] I_ACT_ADDR,
	output logic [7:0] O_ACT_DATA,
	// Status
	output logic O_LSB_FIRST,
	output logic O_SEP_OUT,
	output logic O_UPDATE,
	output logic O_BUSY,
	output logic O_STALLED
);
	typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} scp_dev_state_t;

	scp_dev_state_t state;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic sclk_d;
	logic sclk_q;
	logic cs_high;
	logic sdi;
	logic rise;
	logic fall;
	logic [3:0] bit_cnt;
	logic [15:0] instr_sh;
	logic [7:0] rx_sh;
	logic [7:0] rd_byte;
	logic is_read;
	logic stream;
	logic [1:0] bytes_left;
	logic [9:0] addr;
	logic [7:0] cfg;
	logic [7:0] shadow [scp_pkg::REG_COUNT];
	logic [7:0] active [scp_pkg::REG_COUNT];
	logic lsb;
	logic sep;
	logic rb_active;
	logic [15:0] next_instr;
	logic [7:0] next_rx;
	logic [9:0] next_addr;
	logic byte_end;
	logic wr_en;
	logic upd;
	logic rd_phase;
	logic sdo_bit;
	logic rd_drive;

	// Pins cross into I_CLK through two flip-flops before anything reads them
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sync1 <= 3'h2;
			sync2 <= 3'h2;
			sclk_d <= 1'b0;
		end else begin
			sync1 <= {LINK.sdio_lvl, LINK.cs_n, LINK.sclk};
			sync2 <= sync1;
			sclk_d <= sync2[0];
		end
	end

	assign sclk_q = sync2[0];
	assign cs_high = sync2[1];
	assign sdi = sync2[2];
	assign rise = sclk_q & ~sclk_d & ~cs_high;
	assign fall = ~sclk_q & sclk_d & ~cs_high;

	assign lsb = cfg[scp_pkg::CFG_LSB_LO];
	assign sep = cfg[scp_pkg::CFG_SEP_LO];
	assign rb_active = active[scp_pkg::ADDR_RBSEL][scp_pkg::RBSEL_BIT];

	// Bit order follows the live configuration byte, no update needed (see RQ17)
	always_comb begin
		if (lsb) begin
			next_instr = {sdi, instr_sh[15:1]}; // see RQ19
			next_rx = {sdi, rx_sh[7:1]};
		end else begin
			next_instr = {instr_sh[14:0], sdi}; // see RQ18
			next_rx = {rx_sh[6:0], sdi};
		end
	end

	// Address walk: down and wrapping past zero when MSB first, up when LSB first
	always_comb begin
		if (lsb) begin
			next_addr = addr + 10'h001; // see RQ19
		end else if (addr == scp_pkg::ADDR_CFG) begin
			next_addr = scp_pkg::ADDR_LAST; // see RQ20
		end else begin
			next_addr = addr - 10'h001; // see RQ18
		end
	end

	function automatic logic [7:0] read_value(input logic [9:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == scp_pkg::ADDR_CFG) begin
			v = cfg;
		end else if (a < scp_pkg::ADDR_UPDATE) begin
			v = rb_active ? active[a] : shadow[a]; // see RQ13
		end
		return v;
	endfunction

	assign byte_end = rise && state == ST_DATA && bit_cnt[2:0] == 3'h7;
	assign wr_en = byte_end && !is_read; // see RQ3
	assign upd = wr_en && addr == scp_pkg::ADDR_UPDATE && next_rx[scp_pkg::UPDATE_BIT];

	// Transfer sequencer
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= ST_INSTR;
			bit_cnt <= 4'h0;
			instr_sh <= 16'h0000;
			rx_sh <= 8'h00;
			rd_byte <= 8'h00;
			is_read <= 1'b0;
			stream <= 1'b0;
			bytes_left <= 2'h0;
			addr <= 10'h000;
		end else if (cs_high) begin
			// Mid-byte rise abandons; a boundary rise in a sized transfer only stalls
			if (bit_cnt[2:0] != 3'h0 || state == ST_DONE) begin
				state <= ST_INSTR; // see RQ5
				bit_cnt <= 4'h0;
			end else if (state == ST_DATA && stream) begin
				state <= ST_INSTR; // see RQ4
				bit_cnt <= 4'h0;
			end
		end else if (rise) begin
			case (state)
				ST_INSTR: begin
					instr_sh <= next_instr; // see RQ22
					bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt == 4'(scp_pkg::INSTR_BITS - 1)) begin
						state <= ST_DATA;
						bit_cnt <= 4'h0;
						is_read <= next_instr[scp_pkg::INSTR_RW]; // see RQ1
						bytes_left <= next_instr[scp_pkg::INSTR_LEN_HI:scp_pkg::INSTR_LEN_LO];
						stream <= next_instr[scp_pkg::INSTR_LEN_HI:scp_pkg::INSTR_LEN_LO]
							== scp_pkg::LEN_STREAM; // see RQ2
						// Upper three address bits are ignored (see RQ15)
						addr <= next_instr[scp_pkg::ADDR_W-1:0];
						rd_byte <= read_value(next_instr[scp_pkg::ADDR_W-1:0]);
					end
				end
				ST_DATA: begin
					rx_sh <= next_rx;
					bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt[2:0] == 3'h7) begin
						bit_cnt <= 4'h0;
						if (stream && addr == scp_pkg::ADDR_LAST) begin
							state <= ST_DONE; // see RQ20
						end else if (!stream && bytes_left == 2'h0) begin
							state <= ST_DONE; // see RQ2
						end else begin
							if (!stream) begin
								bytes_left <= bytes_left - 2'h1;
							end
							addr <= next_addr; // see RQ6
							rd_byte <= read_value(next_addr); // see RQ10
						end
					end
				end
				ST_DONE: begin
					bit_cnt <= 4'h0;
				end
				default: begin
					state <= ST_INSTR;
				end
			endcase
		end
	end

	// Configuration byte acts at once; software keeps it mirrored (see RQ16)
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cfg <= scp_pkg::CFG_RESET; // see RQ14
		end else if (wr_en && addr == scp_pkg::ADDR_CFG) begin
			cfg <= next_rx; // see RQ17
		end
	end

	// Shadow bank takes every written byte below the update address except the configuration byte, reserved ones included
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
				shadow[i] <= 8'h00;
			end
		end else if (wr_en && addr < scp_pkg::ADDR_UPDATE && addr != scp_pkg::ADDR_CFG) begin
			shadow[addr] <= next_rx; // see RQ6
		end
	end

	// Update copies the whole shadow bank; pending bytes wait any number of cycles
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
				active[i] <= 8'h00;
			end
		end else if (upd) begin
			active <= shadow; // see RQ8 see RQ9
		end
	end

	// Update bit is never stored, so it reads back cleared
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_UPDATE <= 1'b0;
		end else begin
			O_UPDATE <= upd; // see RQ8
		end
	end

	// Read bit changes after a falling edge so it is settled for the next rising.
	// A stall may end the byte with the clock, hiding that fall; loading while
	// chip select is high keeps the next byte's first bit ready for the resume.
	// Inverting a 3-bit index gives seven minus the index.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sdo_bit <= 1'b0;
			rd_drive <= 1'b0;
		end else if (state != ST_DATA || !is_read) begin
			sdo_bit <= 1'b0;
			rd_drive <= 1'b0;
		end else if (cs_high || fall) begin
			sdo_bit <= rd_byte[lsb ? bit_cnt[2:0] : ~bit_cnt[2:0]]; // see RQ11 see RQ4
			// Pin stays off until the last instruction bit has been taken (see RQ23)
			rd_drive <= 1'b1;
		end
	end

	assign rd_phase = !cs_high && state == ST_DATA && is_read && rd_drive;
	assign LINK.dev_sdio_o = sdo_bit;
	assign LINK.dev_sdo_o = sdo_bit;
	assign LINK.dev_sdio_oe = rd_phase && !sep; // see RQ12 see RQ21 see RQ23
	assign LINK.dev_sdo_oe = rd_phase && sep; // see RQ12 see RQ21

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_ACT_DATA <= 8'h00;
		end else if (I_ACT_ADDR < scp_pkg::ADDR_UPDATE) begin
			O_ACT_DATA <= active[I_ACT_ADDR];
		end else begin
			O_ACT_DATA <= 8'h00;
		end
	end

	assign O_LSB_FIRST = lsb;
	assign O_SEP_OUT = sep;
	assign O_BUSY = state != ST_INSTR || bit_cnt != 4'h0;
	// Waiting on a byte boundary with chip select high (see RQ4)
	assign O_STALLED = cs_high && state == ST_DATA && !stream && bit_cnt == 4'h0;
endmodule
`default_nettype wire

// [src/scp_host.sv]
// Host serial master for the configuration port, programmed over APB
`timescale 1ns/1ps
`default_nettype none
module scp_host (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Serial link
	scp_if.host LINK
);
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_FETCH, H_END} scp_host_state_t;

	scp_host_state_t state;
	logic [1:0] sdio_s;
	logic [1:0] sdo_s;
	logic [17:0] ctrl;
	logic [15:0] instr;
	logic [7:0] tx_byte;
	logic tx_last;
	logic tx_full;
	logic [7:0] cur_byte;
	logic cur_last;
	logic first_byte;
	logic [7:0] rx_sh;
	logic [7:0] rx_data;
	logic rx_valid;
	logic [4:0] tcnt;
	logic [3:0] cnt;
	logic in_instr;
	logic [1:0] left;
	logic half_done;
	logic take;
	logic start;
	logic wr;
	logic rd;
	logic lsb;
	logic is_rd;
	logic stream;
	logic din;
	logic bit_now;
	logic [7:0] fix_byte;

	assign wr = I_PSEL && I_PENABLE && I_PWRITE;
	assign rd = I_PSEL && I_PENABLE && !I_PWRITE;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = 1'b0;
	assign start = wr && I_PADDR == scp_pkg::HREG_CTRL && I_PWDATA[scp_pkg::CTRL_START]
		&& state == H_IDLE;
	assign lsb = ctrl[scp_pkg::CTRL_LSB];
	assign is_rd = instr[scp_pkg::INSTR_RW];
	assign stream = instr[scp_pkg::INSTR_LEN_HI:scp_pkg::INSTR_LEN_LO] == scp_pkg::LEN_STREAM;
	assign half_done = tcnt == 5'(scp_pkg::SCLK_HALF_CYC - 1);
	assign take = state == H_FETCH && tx_full;
	assign din = ctrl[scp_pkg::CTRL_SEP] ? sdo_s[1] : sdio_s[1];

	always_comb begin
		if (in_instr) begin
			bit_now = lsb ? instr[cnt] : instr[~cnt];
		end else begin
			bit_now = lsb ? cur_byte[cnt[2:0]] : cur_byte[~cnt[2:0]];
		end
	end

	// A byte for register zero goes out mirrored, long-instruction bits set, when it is the first byte of the transfer
	always_comb begin
		fix_byte = tx_byte;
		if (first_byte && instr[9:0] == scp_pkg::ADDR_CFG) begin
			fix_byte[scp_pkg::CFG_LONG_HI] = 1'b1; // see RQ14
			fix_byte[scp_pkg::CFG_LONG_LO] = 1'b1;
			fix_byte[7:4] = {fix_byte[0], fix_byte[1], fix_byte[2], fix_byte[3]}; // see RQ16
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sdio_s <= 2'h0;
			sdo_s <= 2'h0;
		end else begin
			sdio_s <= {sdio_s[0], LINK.sdio_lvl};
			sdo_s <= {sdo_s[0], LINK.sdo_lvl};
		end
	end

	// Software registers; a software TX write's set wins over the hardware clear in the same cycle
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl <= 18'h00000;
			tx_byte <= 8'h00;
			tx_last <= 1'b0;
			tx_full <= 1'b0;
		end else begin
			if (start) begin
				ctrl <= I_PWDATA[17:0];
			end
			if (take) begin
				tx_full <= 1'b0;
			end
			if (wr && I_PADDR == scp_pkg::HREG_TX) begin
				tx_byte <= I_PWDATA[7:0]; // see RQ7
				tx_last <= I_PWDATA[scp_pkg::TX_LAST];
				tx_full <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PRDATA <= 32'h00000000;
		end else if (I_PSEL && !I_PENABLE) begin
			case (I_PADDR)
				scp_pkg::HREG_CTRL: O_PRDATA <= {14'h0000, ctrl};
				scp_pkg::HREG_RX: O_PRDATA <= {24'h000000, rx_data};
				scp_pkg::HREG_STAT: O_PRDATA <= {29'h00000000, rx_valid, tx_full, state != H_IDLE};
				default: O_PRDATA <= 32'h00000000;
			endcase
		end
	end

	// Serial sequencer
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= H_IDLE;
			tcnt <= 5'h00;
			cnt <= 4'h0;
			in_instr <= 1'b0;
			instr <= 16'h0000;
			left <= 2'h0;
			cur_byte <= 8'h00;
			cur_last <= 1'b0;
			first_byte <= 1'b0;
			rx_sh <= 8'h00;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			if (rd && I_PADDR == scp_pkg::HREG_RX) begin
				rx_valid <= 1'b0;
			end
			tcnt <= half_done ? 5'h00 : tcnt + 5'h01;
			case (state)
				H_IDLE: begin
					tcnt <= 5'h00;
					if (start) begin
						// Upper address bits forced to zero (see RQ15)
						instr <= {I_PWDATA[15:13], 3'h0, I_PWDATA[9:0]}; // see RQ1
						left <= I_PWDATA[14:13]; // see RQ2
						cnt <= 4'h0;
						in_instr <= 1'b1;
						first_byte <= 1'b1;
						state <= H_LOW;
					end
				end
				H_LOW: begin
					if (half_done) begin
						if (!in_instr && is_rd) begin
							rx_sh <= lsb ? {din, rx_sh[7:1]} : {rx_sh[6:0], din};
						end
						state <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (half_done) begin
						cnt <= cnt + 4'h1;
						state <= H_LOW;
						if (in_instr && cnt == 4'(scp_pkg::INSTR_BITS - 1)) begin
							cnt <= 4'h0;
							in_instr <= 1'b0;
							state <= H_FETCH;
						end else if (!in_instr && cnt == 4'(scp_pkg::BYTE_BITS - 1)) begin
							cnt <= 4'h0;
							first_byte <= 1'b0;
							if (is_rd) begin
								rx_data <= rx_sh;
								rx_valid <= 1'b1;
							end
							left <= left - 2'h1;
							if (stream ? cur_last : left == 2'h0) begin
								state <= H_END; // see RQ4
							end else begin
								state <= H_FETCH;
							end
						end
					end
				end
				H_FETCH: begin
					tcnt <= 5'h00;
					if (tx_full) begin
						cur_byte <= fix_byte;
						cur_last <= tx_last;
						state <= H_LOW;
					end
				end
				H_END: begin
					if (half_done) begin
						state <= H_IDLE;
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	// Sized transfers stall with chip select high between bytes while no TX byte waits; streams keep it low
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			LINK.cs_n <= 1'b1;
			LINK.sclk <= 1'b0;
			LINK.host_sdio_o <= 1'b0;
			LINK.host_sdio_oe <= 1'b0;
		end else begin
			LINK.cs_n <= state == H_IDLE || state == H_END
				|| (state == H_FETCH && !stream && !tx_full); // see RQ4
			LINK.sclk <= state == H_HIGH;
			LINK.host_sdio_o <= bit_now;
			LINK.host_sdio_oe <= (state == H_LOW || state == H_HIGH) && (in_instr || !is_rd);
		end
	end
endmodule
`default_nettype wire

// [dv/scp_checker.sv]
// Link protocol assertions for the host and configuration port pair
`timescale 1ns/1ps
`default_nettype none
module scp_checker (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Link signals
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic host_sdio_o,
	input wire logic dev_sdio_o,
	input wire logic dev_sdio_oe,
	input wire logic dev_sdo_oe
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	// One serial high phase lasts exactly twelve clocks
	sequence s_high12;
		sclk[*8] ##1 sclk[*4] ##1 !sclk;
	endsequence
	// A frame opens with the serial clock held low
	sequence s_low8;
		!sclk[*8];
	endsequence
	a_sclk_high_len: assert property ($rose(sclk) |-> s_high12)
		else $error("serial clock high phase has wrong length");
	a_frame_start: assert property ($fell(cs_n) |-> s_low8)
		else $error("frame started with serial clock high");
	a_idle_clk_low: assert property (cs_n[*2] |-> !sclk)
		else $error("serial clock moved while deselected");
	// Synchronizer lag allows the device a few clocks to release
	a_cs_release: assert property (cs_n[*4] |-> !dev_sdio_oe && !dev_sdo_oe)
		else $error("device drives a pin while deselected");
	a_one_pin: assert property (!(dev_sdio_oe && dev_sdo_oe))
		else $error("readback on both pins at once");
	a_wr_hold: assert property (sclk && $past(sclk) |-> $stable(host_sdio_o))
		else $error("write data moved while serial clock high");
	a_rd_change: assert property (dev_sdio_oe && $changed(dev_sdio_o) |-> !sclk)
		else $error("read data moved while serial clock high");
	a_drive_start: assert property ($rose(dev_sdio_oe) |-> !cs_n && !sclk)
		else $error("data pin driven outside a read phase");
endmodule
`default_nettype wire

// [dv/tb_serial_config_port.sv]
// Testbench for the host controller and configuration port pair
`timescale 1ns/1ps
`default_nettype none
module tb_serial_config_port;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic lsb_first, sep_out, upd, busy, stalled, busy_b, stalled_b;
	logic sdo_seen = 1'b0;
	logic sclk_q = 1'b0;
	logic lsb_mode;
	logic [7:0] paddr, act_data, act_data_b;
	logic [9:0] act_addr;
	logic [15:0] sh = 16'h0000;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] rx [4];
	logic [7:0] z [4] = '{default: 8'h00};
	int errors = 0;
	int compares = 0;
	int upd_cnt = 0;
	scp_if u_scp_if ();
	scp_if u_scp_if_b ();
	scp_host u_scp_host (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(u_scp_if));
	scp_device u_scp_device (.I_CLK(clk), .I_RST_N(rst_n), .LINK(u_scp_if),
		.I_ACT_ADDR(act_addr), .O_ACT_DATA(act_data), .O_LSB_FIRST(lsb_first),
		.O_SEP_OUT(sep_out), .O_UPDATE(upd), .O_BUSY(busy), .O_STALLED(stalled));
	// Second device faces a bit-banged host that breaks framing on purpose
	scp_device u_scp_device_b (.I_CLK(clk), .I_RST_N(rst_n), .LINK(u_scp_if_b),
		.I_ACT_ADDR(act_addr), .O_ACT_DATA(act_data_b), .O_LSB_FIRST(), .O_SEP_OUT(),
		.O_UPDATE(), .O_BUSY(busy_b), .O_STALLED(stalled_b));
	scp_checker u_scp_checker (.I_CLK(clk), .I_RST_N(rst_n), .sclk(u_scp_if.sclk),
		.cs_n(u_scp_if.cs_n), .host_sdio_o(u_scp_if.host_sdio_o),
		.dev_sdio_o(u_scp_if.dev_sdio_o), .dev_sdio_oe(u_scp_if.dev_sdio_oe),
		.dev_sdo_oe(u_scp_if.dev_sdo_oe));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Wire monitor: last sixteen bits seen at serial rising edges
	always @(posedge clk) begin
		sclk_q <= u_scp_if.sclk;
		if (u_scp_if.sclk && !sclk_q)
			sh <= {sh[14:0], u_scp_if.sdio_lvl};
		if (upd === 1'b1)
			upd_cnt <= upd_cnt + 1;
		if (u_scp_if.dev_sdo_oe === 1'b1)
			sdo_seen <= 1'b1;
	end
	task automatic close_out();
		$display("Comparisons %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) begin
			errors++;
			close_out();
		end
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_stat(input int b, input logic v);
		logic [31:0] s;
		for (int n = 0; n < 3000; n++) begin
			apb(1'b0, scp_pkg::HREG_STAT, 32'h0, s);
			if (s[b] === v)
				return;
		end
		errors++;
		close_out();
	endtask
	// Every data byte, read or write, needs its own TX token
	task automatic xfer(input logic rd, input logic [1:0] len, input logic [9:0] a,
		input logic sep, input int nb, input logic [7:0] d [4]);
		logic [31:0] r;
		apb(1'b1, scp_pkg::HREG_CTRL, {1'b1, 13'h0, sep, lsb_mode, rd, len, 3'h0, a}, r);
		for (int i = 0; i < nb; i++) begin
			wait_stat(scp_pkg::STAT_TXFULL, 1'b0);
			apb(1'b1, scp_pkg::HREG_TX, {23'h0, i == nb - 1, d[i]}, r);
			if (rd) begin
				wait_stat(scp_pkg::STAT_RXVALID, 1'b1);
				apb(1'b0, scp_pkg::HREG_RX, 32'h0, r);
				rx[i] = r[7:0];
			end
		end
		wait_stat(scp_pkg::STAT_BUSY, 1'b0);
	endtask
	task automatic wr1(input logic [9:0] a, input logic [7:0] v);
		xfer(1'b0, 2'h0, a, 1'b0, 1, '{v, 8'h00, 8'h00, 8'h00});
	endtask
	task automatic rd1(input logic [9:0] a, input logic [7:0] e);
		xfer(1'b1, 2'h0, a, 1'b0, 1, z);
		chk(rx[0], e);
	endtask
	task automatic act(input logic [9:0] a, input logic [7:0] e);
		act_addr <= a;
		repeat (2) @(posedge clk);
		chk(act_data, e);
	endtask
	task automatic bb(input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			u_scp_if_b.host_sdio_o <= v[i];
			u_scp_if_b.cs_n <= 1'b0;
			repeat (12) @(posedge clk);
			u_scp_if_b.sclk <= 1'b1;
			repeat (12) @(posedge clk);
			u_scp_if_b.sclk <= 1'b0;
		end
	endtask
	task automatic bb_end();
		repeat (12) @(posedge clk);
		u_scp_if_b.cs_n <= 1'b1;
		repeat (24) @(posedge clk);
	endtask
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		act_addr = 10'h000;
		lsb_mode = 1'b0;
		u_scp_if_b.sclk = 1'b0;
		u_scp_if_b.cs_n = 1'b1;
		u_scp_if_b.host_sdio_o = 1'b0;
		u_scp_if_b.host_sdio_oe = 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk(lsb_first, 1'b0);
		chk(sep_out, 1'b0);
		apb(1'b0, 8'h10, 32'h0, q);
		chk(q, 32'h0);
		rd1(scp_pkg::ADDR_CFG, scp_pkg::CFG_RESET);
		xfer(1'b0, 2'h2, 10'h012, 1'b0, 3, '{8'hA1, 8'hB2, 8'hC3, 8'h00});
		wr1(10'h020, 8'h5A);
		chk(sh, 16'h205A);
		act(10'h012, 8'h00);
		wr1(scp_pkg::ADDR_UPDATE, 8'h01);
		chk(upd_cnt, 1);
		act(10'h012, 8'hA1);
		act(10'h011, 8'hB2);
		act(10'h010, 8'hC3);
		act(10'h020, 8'h5A);
		rd1(scp_pkg::ADDR_UPDATE, 8'h00);
		wr1(10'h030, 8'h77);
		rd1(10'h030, 8'h77);
		wr1(scp_pkg::ADDR_RBSEL, 8'h01);
		wr1(scp_pkg::ADDR_UPDATE, 8'h01);
		wr1(10'h030, 8'h66);
		rd1(10'h030, 8'h77);
		xfer(1'b1, scp_pkg::LEN_STREAM, 10'h012, 1'b0, 3, z);
		chk({rx[0], rx[1], rx[2]}, 24'hA1B2C3);
		wr1(scp_pkg::ADDR_CFG, 8'h5A);
		chk(lsb_first, 1'b1);
		lsb_mode = 1'b1;
		// Fourth byte falls past the stop address and must be dropped
		xfer(1'b0, scp_pkg::LEN_STREAM, 10'h230, 1'b0, 4, '{8'h35, 8'h4D, 8'h01, 8'hEE});
		chk(upd_cnt, 3);
		act(10'h230, 8'h35);
		act(10'h231, 8'h4D);
		xfer(1'b1, 2'h1, 10'h230, 1'b0, 2, z);
		chk({rx[0], rx[1]}, 16'h354D);
		chk(sh, 16'hACB2);
		wr1(scp_pkg::ADDR_CFG, scp_pkg::CFG_RESET);
		lsb_mode = 1'b0;
		chk(lsb_first, 1'b0);
		xfer(1'b0, scp_pkg::LEN_STREAM, 10'h001, 1'b0, 3, '{8'h11, 8'h18, 8'h01, 8'h00});
		chk(upd_cnt, 4);
		act(10'h001, 8'h11);
		chk(sdo_seen, 1'b0);
		wr1(scp_pkg::ADDR_CFG, 8'h99);
		chk(sep_out, 1'b1);
		xfer(1'b1, 2'h0, 10'h012, 1'b1, 1, z);
		chk(rx[0], 8'hA1);
		chk(sdo_seen, 1'b1);
		wr1(scp_pkg::ADDR_CFG, scp_pkg::CFG_RESET);
		chk({29'h0, pslverr, busy, stalled}, 32'h0);
		bb(16'h0040, 16);
		bb(16'h000F, 4);
		bb_end();
		chk(busy_b, 1'b0);
		bb(16'h0040, 16);
		bb_end();
		chk(stalled_b, 1'b1);
		bb(16'h00C3, 8);
		bb_end();
		bb(16'h0232, 16);
		bb(16'h0001, 8);
		bb_end();
		act_addr <= 10'h040;
		repeat (2) @(posedge clk);
		chk(act_data_b, 8'hC3);
		close_out();
	end
endmodule
`default_nettype wire
